// ---- hw/tmw_params.svh ----
`ifndef TMW_PARAMS_SVH
`define TMW_PARAMS_SVH
// Register word addresses (one aligned word each)
`define TMW_ADDR_OUT_MODE 8'h24
`define TMW_ADDR_CLK_CTRL 8'h25
`define TMW_ADDR_COUNT 8'h26
`define TMW_ADDR_CMP_A 8'h27
`define TMW_ADDR_CMP_B 8'h28
`define TMW_ADDR_FLAGS 8'h29
// Output mode control fields
`define TMW_CMPA_HI 7
`define TMW_CMPA_LO 6
`define TMW_CMPB_HI 5
`define TMW_CMPB_LO 4
`define TMW_WAVE_HI 1
`define TMW_WAVE_LO 0
`define TMW_OUT_MODE_WMASK 8'hf3
// Clock control fields
`define TMW_WAVE_HIGH_BIT 3
`define TMW_CLK_CTRL_WMASK 8'h08
// Flag register bits
`define TMW_FLAG_OVF 0
`define TMW_FLAG_MA 1
`define TMW_FLAG_MB 2
// Counter values
`define TMW_MAX 8'hff
`define TMW_BOTTOM 8'h00
`define TMW_RESET_BYTE 8'h00
`define TMW_RDATA_ZERO 32'h0000_0000
`endif

// ---- hw/tmw_pkg.sv ----
package tmw_pkg;
  typedef enum logic [2:0] {
    TMW_NORMAL = 3'h0,
    TMW_PC_FF = 3'h1,
    TMW_CTC = 3'h2,
    TMW_FAST_FF = 3'h3,
    TMW_RSVD4 = 3'h4,
    TMW_PC_CMP = 3'h5,
    TMW_RSVD6 = 3'h6,
    TMW_FAST_CMP = 3'h7
  } tmw_wave_mode_t;

  typedef enum logic [1:0] {
    TMW_ACT_OFF = 2'h0,
    TMW_ACT_TOGGLE = 2'h1,
    TMW_ACT_CLEAR = 2'h2,
    TMW_ACT_SET = 2'h3
  } tmw_action_t;

  // Bus answer state, Gray along idle -> answer
  typedef enum logic [0:0] {
    TMW_BUS_IDLE = 1'b0,
    TMW_BUS_ACK = 1'b1
  } tmw_bus_state_t;
endpackage : tmw_pkg

// ---- hw/tmw_timer8_wave.sv ----
// Overview of operation
// - Counter runs on clk_i; timer tick is only a clock enable.
// - Nonzero A action field hands the pin to wave output A, except 01 in PWM without the high mode bit.
// - Non-PWM A actions: off, toggle, clear, set on match.
// - Fast PWM A: 10 clear/set at bottom, 11 inverse, 01 toggle if high mode bit.
// - Fast PWM A: compare equals TOP with high action bit acts at BOTTOM.
// - Phase correct A: 10 clear up, set down; 11 reverse; 01 as fast PWM.
// - Phase correct A: compare equals TOP with high action bit acts at TOP.
// - Nonzero B field takes the pin, except 01 in PWM modes; non-PWM encoding as output A.
// - Fast PWM B: 01 reserved, 10 clear/set at bottom, 11 inverse.
// - Fast PWM B: compare equals TOP with high action bit acts at BOTTOM.
// - Phase correct B: 01 reserved, 10 clear up set down, 11 reverse.
// - Control bits 3 and 2 always read zero.
// - Mode is high bit from clock control plus two low bits here.
// - Normal TOP 0xff, CTC TOP compare A; immediate update, overflow at MAX.
// - Fast PWM 3 TOP 0xff; 7 TOP compare A; both reload at BOTTOM.
// - Phase correct 1 and 5: reload at TOP, overflow at BOTTOM.
// - MAX is the constant 0xff.
// - Fast PWM counts up to TOP then returns to zero next tick.
// - Phase correct reverses at TOP, holding TOP one tick.
//
// The Avalon-MM slave port was left to the implementer.
`include "tmw_params.svh"
module tmw_timer8_wave
  import tmw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Timer tick
  input wire logic timer_tick_enable_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Wave outputs
  output logic wave_out_a_o,
  output logic wave_out_b_o,
  output logic wave_out_a_en_o,
  output logic wave_out_b_en_o,
  output logic overflow_flag_o
);

  logic [7:0] out_mode_q, out_mode_d;
  logic [7:0] clk_ctrl_q, clk_ctrl_d;
  logic [7:0] count_q, count_d;
  logic [7:0] cmp_a_q, cmp_a_d;
  logic [7:0] cmp_b_q, cmp_b_d;
  logic [7:0] cmp_a_buf_q, cmp_a_buf_d;
  logic [7:0] cmp_b_buf_q, cmp_b_buf_d;
  logic down_q, down_d;
  logic [2:0] flags_q, flags_d;
  logic oa_q, oa_d, ob_q, ob_d;
  logic oa_en_q, oa_en_d, ob_en_q, ob_en_d;
  logic ovf_q, ovf_d;
  logic [31:0] rdata_q, rdata_d;
  tmw_bus_state_t bus_q, bus_d;

  tmw_wave_mode_t mode;
  tmw_action_t act_a, act_b;
  logic [7:0] top;
  logic is_fast, is_pc, is_pwm, wr_ok, rd_ok, tick;
  logic at_top, at_bot, hit_a, hit_b, reload, ovf_ev;

  // Mode decode
  always_comb begin
    mode = tmw_wave_mode_t'({clk_ctrl_q[`TMW_WAVE_HIGH_BIT],
                            out_mode_q[`TMW_WAVE_HI:`TMW_WAVE_LO]});
    act_a = tmw_action_t'(out_mode_q[`TMW_CMPA_HI:`TMW_CMPA_LO]);
    act_b = tmw_action_t'(out_mode_q[`TMW_CMPB_HI:`TMW_CMPB_LO]);
    is_fast = (mode == TMW_FAST_FF) || (mode == TMW_FAST_CMP);
    is_pc = (mode == TMW_PC_FF) || (mode == TMW_PC_CMP);
    is_pwm = is_fast || is_pc;
    // Reserved modes 4 and 6 decode as a plain up count to MAX
    // Compare A register sets TOP in modes 2, 5, 7
    if ((mode == TMW_CTC) || (mode == TMW_PC_CMP) || (mode == TMW_FAST_CMP)) begin
      top = cmp_a_q;
    end else begin
      top = `TMW_MAX;
    end
  end

  // Counter, buffered compares and overflow
  always_comb begin
    tick = timer_tick_enable_i;
    at_top = (count_q == top);
    at_bot = (count_q == `TMW_BOTTOM);
    count_d = count_q;
    down_d = down_q;
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    reload = 1'b0;
    ovf_ev = 1'b0;
    if (tick) begin
      if (is_pc) begin
        if (!down_q && at_top) begin
          // TOP shows for one tick only, so a slope pair spans twice TOP ticks
          down_d = 1'b1;
          count_d = count_q - 8'h01;
        end else if (down_q && at_bot) begin
          down_d = 1'b0;
          count_d = count_q + 8'h01;
        end else if (down_q) begin
          count_d = count_q - 8'h01;
        end else begin
          count_d = count_q + 8'h01;
        end
        reload = at_top;
        ovf_ev = at_bot && down_q;
      end else begin
        if (at_top) begin
          count_d = `TMW_BOTTOM;
        end else begin
          count_d = count_q + 8'h01;
        end
        down_d = 1'b0;
        if (mode == TMW_FAST_CMP) begin
          reload = at_top; // Reload lands as the count becomes BOTTOM
          ovf_ev = at_top;
        end else begin
          reload = is_fast && at_top;
          ovf_ev = (count_q == `TMW_MAX);
        end
      end
    end
    // A software count write wins over counting in that cycle
    if (wr_ok && (avs_address_i == `TMW_ADDR_COUNT)) begin
      count_d = avs_writedata_i[7:0];
    end
    // Non-PWM modes update compare registers immediately
    if (!is_pwm || reload) begin
      cmp_a_d = cmp_a_buf_q;
      cmp_b_d = cmp_b_buf_q;
    end
  end

  // Compare output actions
  always_comb begin
    hit_a = tick && (count_q == cmp_a_q);
    hit_b = tick && (count_q == cmp_b_q);
    oa_d = oa_q;
    ob_d = ob_q;
    oa_en_d = (act_a != TMW_ACT_OFF);
    ob_en_d = (act_b != TMW_ACT_OFF);
    // Reserved codes hand the pin back to the port rather than show a stale level
    if (is_pwm && (act_a == TMW_ACT_TOGGLE) && !clk_ctrl_q[`TMW_WAVE_HIGH_BIT]) begin
      oa_en_d = 1'b0;
    end
    if (is_fast && (act_b == TMW_ACT_TOGGLE)) begin
      ob_en_d = 1'b0;
    end
    if (is_pc && (act_b == TMW_ACT_TOGGLE)) begin
      ob_en_d = 1'b0;
    end
    if (!is_pwm) begin
      if (hit_a) begin
        unique case (act_a)
          TMW_ACT_OFF: oa_d = oa_q;
          TMW_ACT_TOGGLE: oa_d = !oa_q;
          TMW_ACT_CLEAR: oa_d = 1'b0;
          TMW_ACT_SET: oa_d = 1'b1;
        endcase
      end
      if (hit_b) begin
        unique case (act_b)
          TMW_ACT_OFF: ob_d = ob_q;
          TMW_ACT_TOGGLE: ob_d = !ob_q;
          TMW_ACT_CLEAR: ob_d = 1'b0;
          TMW_ACT_SET: ob_d = 1'b1;
        endcase
      end
    end else if (is_fast) begin
      if (act_a == TMW_ACT_TOGGLE) begin
        if (hit_a && clk_ctrl_q[`TMW_WAVE_HIGH_BIT]) begin
          oa_d = !oa_q;
        end
      end else if (act_a[1]) begin
        // Match at TOP is ignored so the bottom action wins
        if (tick && at_top) begin
          oa_d = (act_a == TMW_ACT_CLEAR);
        end else if (hit_a) begin
          oa_d = (act_a == TMW_ACT_SET);
        end
      end
      if (act_b[1]) begin
        if (tick && at_top) begin
          ob_d = (act_b == TMW_ACT_CLEAR);
        end else if (hit_b) begin
          ob_d = (act_b == TMW_ACT_SET);
        end
      end
    end else begin
      if (act_a == TMW_ACT_TOGGLE) begin
        if (hit_a && clk_ctrl_q[`TMW_WAVE_HIGH_BIT]) begin
          oa_d = !oa_q;
        end
      end else if (act_a[1]) begin
        if (tick && at_top && (cmp_a_q == top)) begin
          oa_d = (act_a == TMW_ACT_SET); // Up-count result at TOP
        end else if (hit_a) begin
          oa_d = (act_a == TMW_ACT_SET) ^ down_q;
        end
      end
      if (act_b[1]) begin
        if (tick && at_top && (cmp_b_q == top)) begin
          ob_d = (act_b == TMW_ACT_SET);
        end else if (hit_b) begin
          ob_d = (act_b == TMW_ACT_SET) ^ down_q;
        end
      end
    end
  end

  // Register writes, flags and overflow indicator
  always_comb begin
    // Writes land at the answer edge, the one edge where the master sees waitrequest low
    wr_ok = avs_write_i && (bus_q == TMW_BUS_ACK) && avs_byteenable_i[0];
    out_mode_d = out_mode_q;
    clk_ctrl_d = clk_ctrl_q;
    cmp_a_buf_d = cmp_a_buf_q;
    cmp_b_buf_d = cmp_b_buf_q;
    ovf_d = ovf_q;
    // Hardware set wins over a same-cycle software clear
    flags_d = flags_q | {hit_b, hit_a, ovf_ev};
    if (wr_ok) begin
      unique case (avs_address_i)
        `TMW_ADDR_OUT_MODE: out_mode_d = avs_writedata_i[7:0] & `TMW_OUT_MODE_WMASK;
        `TMW_ADDR_CLK_CTRL: clk_ctrl_d = avs_writedata_i[7:0] & `TMW_CLK_CTRL_WMASK;
        `TMW_ADDR_COUNT: ;
        `TMW_ADDR_CMP_A: cmp_a_buf_d = avs_writedata_i[7:0];
        `TMW_ADDR_CMP_B: cmp_b_buf_d = avs_writedata_i[7:0];
        `TMW_ADDR_FLAGS: flags_d = (flags_q & ~avs_writedata_i[2:0]) | {hit_b, hit_a, ovf_ev};
        default: ;
      endcase
    end
    if (ovf_ev) begin
      ovf_d = !ovf_q;
    end
  end

  // Register bus, one wait state then answer
  always_comb begin
    rd_ok = avs_read_i && (bus_q == TMW_BUS_IDLE);
    bus_d = ((avs_read_i || avs_write_i) && (bus_q == TMW_BUS_IDLE)) ? TMW_BUS_ACK
                                                                       : TMW_BUS_IDLE;
    // Read data is registered, so it stands through the answer cycle
    rdata_d = rdata_q;
    if (rd_ok) begin
      unique case (avs_address_i)
        `TMW_ADDR_OUT_MODE: rdata_d = {24'h0, out_mode_q};
        `TMW_ADDR_CLK_CTRL: rdata_d = {24'h0, clk_ctrl_q};
        `TMW_ADDR_COUNT: rdata_d = {24'h0, count_q};
        `TMW_ADDR_CMP_A: rdata_d = {24'h0, cmp_a_buf_q};
        `TMW_ADDR_CMP_B: rdata_d = {24'h0, cmp_b_buf_q};
        `TMW_ADDR_FLAGS: rdata_d = {29'h0, flags_q};
        default: rdata_d = `TMW_RDATA_ZERO;
      endcase
    end
  end

  // Control and buffer registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_mode_q <= `TMW_RESET_BYTE;
      clk_ctrl_q <= `TMW_RESET_BYTE;
      cmp_a_buf_q <= `TMW_RESET_BYTE;
      cmp_b_buf_q <= `TMW_RESET_BYTE;
    end else begin
      out_mode_q <= out_mode_d;
      clk_ctrl_q <= clk_ctrl_d;
      cmp_a_buf_q <= cmp_a_buf_d;
      cmp_b_buf_q <= cmp_b_buf_d;
    end
  end

  // Counter, direction and active compare values
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_q <= `TMW_BOTTOM;
      down_q <= 1'b0;
      cmp_a_q <= `TMW_RESET_BYTE;
      cmp_b_q <= `TMW_RESET_BYTE;
    end else begin
      count_q <= count_d;
      down_q <= down_d;
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
    end
  end

  // Flags and overflow indicator
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flags_q <= 3'h0;
      ovf_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      ovf_q <= ovf_d;
    end
  end

  // Wave outputs and pin ownership
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      oa_q <= 1'b0;
      ob_q <= 1'b0;
      oa_en_q <= 1'b0;
      ob_en_q <= 1'b0;
    end else begin
      oa_q <= oa_d;
      ob_q <= ob_d;
      oa_en_q <= oa_en_d;
      ob_en_q <= ob_en_d;
    end
  end

  // Bus answer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= `TMW_RDATA_ZERO;
      bus_q <= TMW_BUS_IDLE;
    end else begin
      rdata_q <= rdata_d;
      bus_q <= bus_d;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    avs_readdata_o = rdata_q;
    avs_waitrequest_o = (bus_q == TMW_BUS_IDLE);
    wave_out_a_o = oa_q;
    wave_out_b_o = ob_q;
    wave_out_a_en_o = oa_en_q;
    wave_out_b_en_o = ob_en_q;
    overflow_flag_o = ovf_q;
  end

endmodule : tmw_timer8_wave

// ---- sim/tmw_timer8_wave_assertions.sv ----
`include "tmw_params.svh"
module tmw_timer8_wave_assertions (
  // Clock, reset, tick
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic timer_tick_enable_i,
  // Register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Wave outputs
  input wire logic wave_out_a_o,
  input wire logic wave_out_b_o,
  input wire logic wave_out_a_en_o,
  input wire logic wave_out_b_en_o,
  input wire logic overflow_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] om_q;
  logic [7:0] om_d;
  logic ea_x;
  logic eb_x;
  logic unm;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow of the output mode register, taken on the same edge as the slave
  always_comb begin
    om_d = om_q;
    if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i == `TMW_ADDR_OUT_MODE) begin
      om_d = avs_writedata_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    om_q <= sys_rst_i ? 8'h00 : om_d;
  end
  // PWM modes all have the low mode bit set; A 01 in PWM depends on the high bit
  assign ea_x = om_q[7:6] != 2'h0 && !(om_q[7:6] == 2'h1 && om_q[0]);
  assign eb_x = om_q[5:4] != 2'h0 && !(om_q[5:4] == 2'h1 && om_q[0]);
  assign unm = avs_address_i < `TMW_ADDR_OUT_MODE || avs_address_i > `TMW_ADDR_FLAGS;
  sequence s_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_bus_answer: assert property (s_take |=> s_answer)
    else $error("bus answer not one low cycle");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (s_take ##0 avs_read_i && unm |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_rsvd_read_zero: assert property (
    s_take ##0 avs_read_i && avs_address_i == `TMW_ADDR_OUT_MODE |=> avs_readdata_o[3:2] == 2'h0)
    else $error("reserved bits read nonzero");
  a_en_a_match: assert property (om_q == $past(om_q) && (om_q[7:6] != 2'h1 || !om_q[0])
    |-> wave_out_a_en_o == ea_x)
    else $error("pin A ownership wrong");
  a_en_b_match: assert property (om_q == $past(om_q) |-> wave_out_b_en_o == eb_x)
    else $error("pin B ownership wrong");
  a_reset_vals: assert property ($fell(sys_rst_i) |-> avs_waitrequest_o && !wave_out_a_o
    && !wave_out_b_o && !wave_out_a_en_o && !wave_out_b_en_o && !overflow_flag_o)
    else $error("outputs not at reset values");
  a_ovf_tick: assert property ($changed(overflow_flag_o)
    |-> $past(timer_tick_enable_i) || $past(timer_tick_enable_i, 2))
    else $error("overflow moved without tick");
  a_wave_tick: assert property ($changed(wave_out_a_o)
    |-> $past(timer_tick_enable_i) || $past(timer_tick_enable_i, 2))
    else $error("output A moved without tick");
endmodule : tmw_timer8_wave_assertions

bind tmw_timer8_wave tmw_timer8_wave_assertions u_chk (.clk_i, .sys_rst_i,
  .timer_tick_enable_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .wave_out_a_o, .wave_out_b_o,
  .wave_out_a_en_o, .wave_out_b_en_o, .overflow_flag_o);

// ---- sim/tmw_timer8_wave_tb.sv ----
`include "tmw_params.svh"
module tmw_timer8_wave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic timer_tick_enable_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic [31:0] rd;
  logic avs_waitrequest_o, wave_out_a_o, wave_out_b_o, wave_out_a_en_o, wave_out_b_en_o;
  logic overflow_flag_o;
  int fail_count = 0;
  int n_tests = 0;
  int p;
  typedef struct {logic [7:0] hi; logic [7:0] om; logic ea; logic eb;} tmw_row_t;
  tmw_row_t rows [7] = '{
    '{8'h00, 8'h00, 1'b0, 1'b0},
    '{8'h00, 8'h50, 1'b1, 1'b1},
    '{8'h00, 8'h53, 1'b0, 1'b0},
    '{8'h08, 8'h53, 1'b1, 1'b0},
    '{8'h08, 8'h51, 1'b1, 1'b0},
    '{8'h00, 8'hfd, 1'b1, 1'b1},
    '{8'h00, 8'h41, 1'b0, 1'b0}
  };
  always #4 clk_i = ~clk_i;
  tmw_timer8_wave u_dut (.clk_i, .sys_rst_i, .timer_tick_enable_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .wave_out_a_o, .wave_out_b_o, .wave_out_a_en_o, .wave_out_b_en_o,
    .overflow_flag_o);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request stands until a rising edge samples waitrequest low; only the watchdog ends a wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rdchk
  // Cycles between two rising edges of A, B or the overflow toggle; -1 if none
  task automatic per(input int s, output int q);
    logic v, pv;
    int t, t0, k;
    k = 0;
    t = 0;
    t0 = 0;
    q = -1;
    pv = 1'b1;
    while (k < 2 && t < 1200) begin
      @(negedge clk_i);
      t++;
      v = s == 0 ? wave_out_a_o : s == 1 ? wave_out_b_o : overflow_flag_o;
      if (v === 1'b1 && pv === 1'b0) begin
        if (k == 1) q = t - t0;
        t0 = t;
        k++;
      end
      pv = v;
    end
    @(posedge clk_i);
  endtask : per
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #100000;
    chk(32'h1, 32'h0);
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 8'h24; i <= 8'h29; i++) rdchk(8'(i), 8'h00);
    bus(1'b1, 8'h40, 8'h5a);
    rdchk(8'h40, 8'h00);
    avs_byteenable_i <= 4'h0;
    bus(1'b1, `TMW_ADDR_CMP_A, 8'h5a);
    avs_byteenable_i <= 4'hf;
    rdchk(`TMW_ADDR_CMP_A, 8'h00);
    $display("%0t reset test done", $time);
    foreach (rows[i]) begin
      bus(1'b1, `TMW_ADDR_CLK_CTRL, rows[i].hi);
      bus(1'b1, `TMW_ADDR_OUT_MODE, rows[i].om);
      rdchk(`TMW_ADDR_OUT_MODE, rows[i].om & 8'hf3);
      rdchk(`TMW_ADDR_CLK_CTRL, rows[i].hi & 8'h08);
      @(negedge clk_i);
      chk({30'h0, wave_out_a_en_o, wave_out_b_en_o}, {30'h0, rows[i].ea, rows[i].eb});
      @(posedge clk_i);
    end
    $display("%0t row test done", $time);
    bus(1'b1, `TMW_ADDR_OUT_MODE, 8'h42);
    bus(1'b1, `TMW_ADDR_CMP_A, 8'h03);
    bus(1'b1, `TMW_ADDR_CMP_B, 8'h03);
    bus(1'b1, `TMW_ADDR_COUNT, 8'h00);
    timer_tick_enable_i <= 1'b1;
    per(0, p);
    chk(p, 8);
    bus(1'b1, `TMW_ADDR_CMP_A, 8'h09);
    bus(1'b1, `TMW_ADDR_OUT_MODE, 8'h23);
    bus(1'b1, `TMW_ADDR_CLK_CTRL, 8'h08);
    per(1, p);
    chk(p, 10);
    per(2, p);
    chk(p, 20);
    bus(1'b1, `TMW_ADDR_OUT_MODE, 8'h21);
    per(1, p);
    chk(p, 18);
    per(2, p);
    chk(p, 36);
    $display("%0t short top test done", $time);
    bus(1'b1, `TMW_ADDR_CLK_CTRL, 8'h00);
    bus(1'b1, `TMW_ADDR_OUT_MODE, 8'ha3);
    bus(1'b1, `TMW_ADDR_CMP_A, 8'h40);
    per(0, p);
    chk(p, 256);
    per(2, p);
    chk(p, 512);
    bus(1'b1, `TMW_ADDR_CMP_A, 8'hff);
    repeat (600) @(posedge clk_i);
    per(0, p);
    chk(p, 32'hffff_ffff);
    @(negedge clk_i);
    chk({31'h0, wave_out_a_o}, 32'h1);
    @(posedge clk_i);
    bus(1'b1, `TMW_ADDR_OUT_MODE, 8'h00);
    per(2, p);
    chk(p, 512);
    timer_tick_enable_i <= 1'b0;
    per(2, p);
    chk(p, 32'hffff_ffff);
    $display("%0t full top test done", $time);
    bus(1'b1, `TMW_ADDR_OUT_MODE, 8'h50);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(`TMW_ADDR_OUT_MODE, 8'h00);
    rdchk(`TMW_ADDR_FLAGS, 8'h00);
    @(negedge clk_i);
    chk({30'h0, wave_out_a_en_o, wave_out_b_en_o}, 32'h0);
    $display("%0t mid-run reset test done", $time);
    final_report;
  end
endmodule : tmw_timer8_wave_tb
